// *** logic/event_edge.sv ***
`timescale 1ns/1ps
module event_edge #(
   parameter int unsigned WIDTH = 8
) (
   // Clock and reset
   input wire logic mclk,
   input wire logic srst,
   // Levels and their edges
   input wire logic [WIDTH-1:0] level,
   output logic [WIDTH-1:0] rise,
   output logic [WIDTH-1:0] fall
);

   // ==========================================================
   // Previous levels
   logic [WIDTH-1:0] prev;
   logic [WIDTH-1:0] next_prev;

   always_comb begin
      next_prev = level;
   end

   always_ff @(posedge mclk) begin
      if (srst) begin
         prev <= '0;
      end else begin
         prev <= next_prev;
      end
   end

   // ==========================================================
   // Per-bit edges
   genvar i;
   generate
      for (i = 0; i < WIDTH; i++) begin : g_bit
         assign rise[i] = level[i] & ~prev[i];
         assign fall[i] = ~level[i] & prev[i];
      end
   endgenerate

endmodule // event_edge

// *** logic/host_interrupt_status_logic.sv ***
`timescale 1ns/1ps
// How it works
// - Interrupt high when enabled status bit set.
// - Reads keep status; write one clears bits 15-8 and 6.
// - Any link state change sets bit 15.
// - Transmit queue frame sent sets bit 14.
// - Receive queue frame ready sets bit 13.
// - Capture ready or egress timestamp sets 12.
// - Receive overrun sets bit 11.
// - Trigger unit done or error sets 10.
// - Transmit process stop sets bit 9.
// - Receive process stop sets bit 8.
// - Transmit space available sets bit 6.
// - Wake frame bit 5, cleared by 1000.
// - Wake packet bit 4, cleared by 0100.
// - Link-up wake bit 3, cleared by 0010.
// - Energy wake bit 2 when enabled; 0001 clears.
// - Enable bits 12, 10 read PTP enable ORs.
module host_interrupt_status_logic (
   // Clock and reset
   input wire logic mclk,
   input wire logic srst,
   // Avalon-MM slave
   input wire irq_status_pkg::avalon_req_t bus,
   output logic waitrequest,
   output logic [irq_status_pkg::DATA_W-1:0] readdata,
   // Event sources
   input wire irq_status_pkg::event_src_t events,
   // PTP unit enables
   input wire logic [irq_status_pkg::PTP_UNITS-1:0] ptp_ts_enables,
   input wire logic [irq_status_pkg::PTP_UNITS-1:0] ptp_trig_enables,
   // Interrupt
   output logic irq
);

   default clocking cb @(posedge mclk);
   endclocking
   default disable iff (srst);

   // ==========================================================
   // Address decode
   function automatic logic hit(input logic [irq_status_pkg::ADDR_W-1:0] addr,
                                input logic [irq_status_pkg::ADDR_W-1:0] target);
      hit = (addr == target);
   endfunction

   // ==========================================================
   // Event edges
   irq_status_pkg::event_src_t rise_ev;
   irq_status_pkg::event_src_t fall_ev;
   logic [$bits(irq_status_pkg::event_src_t)-1:0] rise_raw;
   logic [$bits(irq_status_pkg::event_src_t)-1:0] fall_raw;

   event_edge #(
      .WIDTH($bits(irq_status_pkg::event_src_t))
   ) u_edge (
      .mclk(mclk),
      .srst(srst),
      .level(events),
      .rise(rise_raw),
      .fall(fall_raw)
   );

   assign rise_ev = rise_raw;
   assign fall_ev = fall_raw;

   // ==========================================================
   // Bus handshake
   logic ack;
   logic next_ack;
   logic req_any;
   logic wr_take;
   logic rd_first;

   assign req_any = bus.read | bus.write;
   // One wait cycle on every access; the answer comes at the second edge
   assign waitrequest = req_any & ~ack;
   assign wr_take = bus.write & ack;
   assign rd_first = bus.read & ~ack;

   always_comb begin
      next_ack = req_any & ~ack;
   end

   always_ff @(posedge mclk) begin
      if (srst) begin
         ack <= 1'b0;
      end else begin
         ack <= next_ack;
      end
   end

   // ==========================================================
   // Registers
   logic [irq_status_pkg::REG_W-1:0] enable_rw;
   logic [irq_status_pkg::REG_W-1:0] pm_ctrl;
   logic [irq_status_pkg::REG_W-1:0] status;
   logic [irq_status_pkg::DATA_W-1:0] rdata;
   logic [irq_status_pkg::REG_W-1:0] next_enable_rw;
   logic [irq_status_pkg::REG_W-1:0] next_pm_ctrl;
   logic [irq_status_pkg::REG_W-1:0] next_status;
   logic [irq_status_pkg::DATA_W-1:0] next_rdata;
   logic [irq_status_pkg::REG_W-1:0] enable_view;
   logic [irq_status_pkg::REG_W-1:0] lane_mask;
   logic [irq_status_pkg::REG_W-1:0] wdata;
   logic [irq_status_pkg::REG_W-1:0] set_vec;
   logic [irq_status_pkg::REG_W-1:0] clr_w1c;
   logic [irq_status_pkg::REG_W-1:0] clr_wake;
   logic [3:0] pm_code;

   assign lane_mask = {{8{bus.byteenable[1]}}, {8{bus.byteenable[0]}}};
   assign wdata = bus.writedata[irq_status_pkg::REG_W-1:0];
   assign pm_code = wdata[irq_status_pkg::PM_FIELD_HI:irq_status_pkg::PM_FIELD_LO];

   // Enable bits 12 and 10 follow the PTP unit enables, never storage
   always_comb begin
      enable_view = enable_rw & irq_status_pkg::ENABLE_RW_MASK;
      enable_view[irq_status_pkg::BIT_TIMESTAMP] = |ptp_ts_enables;
      enable_view[irq_status_pkg::BIT_TRIGGER] = |ptp_trig_enables;
   end

   // ==========================================================
   // Status events
   always_comb begin
      set_vec = '0;
      set_vec[irq_status_pkg::BIT_LINK] = rise_ev.link_state | fall_ev.link_state;
      set_vec[irq_status_pkg::BIT_TX_DONE] = rise_ev.tx_done;
      set_vec[irq_status_pkg::BIT_RX_READY] = rise_ev.rx_ready;
      set_vec[irq_status_pkg::BIT_TIMESTAMP] = |rise_ev.capture_unit_ready
                                               | rise_ev.egress_ts_ready;
      set_vec[irq_status_pkg::BIT_RX_OVERRUN] = rise_ev.rx_overrun;
      set_vec[irq_status_pkg::BIT_TRIGGER] = |rise_ev.trig_done
                                             | |rise_ev.trig_error;
      set_vec[irq_status_pkg::BIT_TX_STOP] = rise_ev.tx_stopped;
      set_vec[irq_status_pkg::BIT_RX_STOP] = rise_ev.rx_stopped;
      set_vec[irq_status_pkg::BIT_TX_SPACE] = rise_ev.tx_space;
      set_vec[irq_status_pkg::BIT_WAKE_FRAME] = rise_ev.wake_frame;
      set_vec[irq_status_pkg::BIT_WAKE_PACKET] = rise_ev.wake_packet;
      set_vec[irq_status_pkg::BIT_LINKUP_WAKE] = rise_ev.linkup_wake;
      // Energy wake is only recorded while its enable is on
      set_vec[irq_status_pkg::BIT_ENERGY_WAKE] = rise_ev.energy_wake
         & enable_rw[irq_status_pkg::BIT_ENERGY_WAKE];
   end

   // ==========================================================
   // Next register values
   always_comb begin
      next_enable_rw = enable_rw;
      next_pm_ctrl = pm_ctrl;
      clr_w1c = '0;
      clr_wake = '0;
      next_rdata = rdata;
      if (wr_take && hit(bus.address, irq_status_pkg::ADDR_ENABLE)) begin
         next_enable_rw = ((enable_rw & ~lane_mask) | (wdata & lane_mask))
                          & irq_status_pkg::ENABLE_RW_MASK;
      end
      if (wr_take && hit(bus.address, irq_status_pkg::ADDR_STATUS)) begin
         // Wake bits are read-only here
         clr_w1c = wdata & lane_mask & irq_status_pkg::STATUS_W1C_MASK;
      end
      if (wr_take && hit(bus.address, irq_status_pkg::ADDR_POWER_MGMT_CONTROL)) begin
         next_pm_ctrl = (pm_ctrl & ~lane_mask) | (wdata & lane_mask);
         if (bus.byteenable[0]) begin
            unique case (pm_code)
               irq_status_pkg::PM_CLR_FRAME: begin
                  clr_wake[irq_status_pkg::BIT_WAKE_FRAME] = 1'b1;
               end
               irq_status_pkg::PM_CLR_PACKET: begin
                  clr_wake[irq_status_pkg::BIT_WAKE_PACKET] = 1'b1;
               end
               irq_status_pkg::PM_CLR_LINKUP: begin
                  clr_wake[irq_status_pkg::BIT_LINKUP_WAKE] = 1'b1;
               end
               irq_status_pkg::PM_CLR_ENERGY: begin
                  clr_wake[irq_status_pkg::BIT_ENERGY_WAKE] = 1'b1;
               end
               default: begin
                  clr_wake = '0;
               end
            endcase
         end
      end
      // A new event wins over a clear in the same cycle; reads clear nothing
      next_status = ((status & ~(clr_w1c | clr_wake)) | set_vec)
                    & irq_status_pkg::STATUS_IMPL_MASK;
      // Read data is captured in the wait cycle and held until the answer
      if (rd_first) begin
         if (hit(bus.address, irq_status_pkg::ADDR_ENABLE)) begin
            next_rdata = {16'h0000, enable_view};
         end else if (hit(bus.address, irq_status_pkg::ADDR_STATUS)) begin
            next_rdata = {16'h0000, status};
         end else if (hit(bus.address, irq_status_pkg::ADDR_POWER_MGMT_CONTROL)) begin
            next_rdata = {16'h0000, pm_ctrl};
         end else begin
            next_rdata = 32'h0000_0000;
         end
      end
   end

   always_ff @(posedge mclk) begin
      if (srst) begin
         enable_rw <= irq_status_pkg::REG_RESET;
         pm_ctrl <= irq_status_pkg::REG_RESET;
         status <= irq_status_pkg::REG_RESET;
         rdata <= 32'h0000_0000;
      end else begin
         enable_rw <= next_enable_rw;
         pm_ctrl <= next_pm_ctrl;
         status <= next_status;
         rdata <= next_rdata;
      end
   end

   assign readdata = rdata;

   // ==========================================================
   // Interrupt output: follows status and enables with no delay
   assign irq = |(status & enable_view);

   // ==========================================================
   // Checks
   // The level must follow a newly latched enabled bit at the next edge
   AST_IRQ_ON: assert property (
      (|(set_vec & enable_rw & irq_status_pkg::ENABLE_RW_MASK) && !wr_take)
      |=> irq)
      else $error("interrupt low with an enabled status bit set");
   // Clearing every bit with nothing new must drop the level at once
   AST_IRQ_OFF: assert property (
      (wr_take && hit(bus.address, irq_status_pkg::ADDR_STATUS)
       && &lane_mask && &wdata && set_vec == 16'h0000
       && (status & irq_status_pkg::STATUS_WAKE_MASK) == 16'h0000)
      |=> !irq)
      else $error("interrupt high with nothing enabled and set");
   AST_READ_KEEPS: assert property ((bus.read && ack) |=> (status & $past(status))
                                    == $past(status))
      else $error("status bit lost across a read");
   AST_W1C: assert property ((wr_take && hit(bus.address, irq_status_pkg::ADDR_STATUS)
                              && wdata[irq_status_pkg::BIT_TX_DONE] && bus.byteenable[1]
                              && !set_vec[irq_status_pkg::BIT_TX_DONE])
                             |=> !status[irq_status_pkg::BIT_TX_DONE])
      else $error("write of one did not clear status");
   AST_LINK: assert property ((rise_ev.link_state || fall_ev.link_state)
                              |=> status[irq_status_pkg::BIT_LINK])
      else $error("link change not recorded");
   AST_TX_DONE: assert property (rise_ev.tx_done
                                 |=> status[irq_status_pkg::BIT_TX_DONE])
      else $error("transmit done not recorded");
   AST_RX_READY: assert property (rise_ev.rx_ready
                                  |=> status[irq_status_pkg::BIT_RX_READY] ##1
                                  (status[irq_status_pkg::BIT_RX_READY]
                                   || $past(clr_w1c[irq_status_pkg::BIT_RX_READY])))
      else $error("receive ready not recorded or not sticky");
   AST_TIMESTAMP: assert property ((|rise_ev.capture_unit_ready || rise_ev.egress_ts_ready)
                                   |=> status[irq_status_pkg::BIT_TIMESTAMP])
      else $error("timestamp event not recorded");
   AST_OVERRUN: assert property (rise_ev.rx_overrun
                                 |=> status[irq_status_pkg::BIT_RX_OVERRUN])
      else $error("overrun not recorded");
   AST_TRIGGER: assert property ((|rise_ev.trig_done || |rise_ev.trig_error)
                                 |=> status[irq_status_pkg::BIT_TRIGGER])
      else $error("trigger event not recorded");
   AST_STOPS: assert property ((rise_ev.tx_stopped |=> status[irq_status_pkg::BIT_TX_STOP])
                               and (rise_ev.rx_stopped
                                    |=> status[irq_status_pkg::BIT_RX_STOP]))
      else $error("process stop not recorded");
   AST_SPACE: assert property (rise_ev.tx_space
                               |=> status[irq_status_pkg::BIT_TX_SPACE])
      else $error("transmit space not recorded");
   AST_WAKE_CLR: assert property ((wr_take && hit(bus.address, irq_status_pkg::ADDR_POWER_MGMT_CONTROL)
                                   && bus.byteenable[0]
                                   && pm_code == irq_status_pkg::PM_CLR_FRAME
                                   && !rise_ev.wake_frame)
                                  |=> !status[irq_status_pkg::BIT_WAKE_FRAME])
      else $error("wake frame bit not cleared by power field");
   AST_WAKE_RO: assert property ((wr_take && hit(bus.address, irq_status_pkg::ADDR_STATUS)
                                  && status[irq_status_pkg::BIT_WAKE_PACKET])
                                 |=> status[irq_status_pkg::BIT_WAKE_PACKET])
      else $error("wake packet bit cleared by a status write");
   AST_ENERGY: assert property ((rise_ev.energy_wake
                                 && !enable_rw[irq_status_pkg::BIT_ENERGY_WAKE]
                                 && !status[irq_status_pkg::BIT_ENERGY_WAKE])
                                |=> !status[irq_status_pkg::BIT_ENERGY_WAKE])
      else $error("energy wake recorded while disabled");
   AST_RESERVED: assert property ((status & ~irq_status_pkg::STATUS_IMPL_MASK)
                                  == 16'h0000)
      else $error("reserved status bit set");
   AST_ENABLE_OR: assert property (enable_view[irq_status_pkg::BIT_TRIGGER]
                                   == |ptp_trig_enables)
      else $error("trigger enable does not follow unit enables");
   AST_WAIT: assert property ($rose(req_any) |-> waitrequest ##1 !waitrequest)
      else $error("access not answered after one wait cycle");

   // ==========================================================
   // Clear paths and register storage
   // Each clear code must reach its own wake bit
   AST_PM_PACKET: assert property (
      (wr_take && hit(bus.address, irq_status_pkg::ADDR_POWER_MGMT_CONTROL)
       && bus.byteenable[0]
       && pm_code == irq_status_pkg::PM_CLR_PACKET
       && !rise_ev.wake_packet)
      |=> !status[irq_status_pkg::BIT_WAKE_PACKET])
      else $error("wake packet bit not cleared");
   AST_PM_LINKUP: assert property (
      (wr_take && hit(bus.address, irq_status_pkg::ADDR_POWER_MGMT_CONTROL)
       && bus.byteenable[0]
       && pm_code == irq_status_pkg::PM_CLR_LINKUP
       && !rise_ev.linkup_wake)
      |=> !status[irq_status_pkg::BIT_LINKUP_WAKE])
      else $error("link-up wake bit not cleared");
   AST_PM_ENERGY: assert property (
      (wr_take && hit(bus.address, irq_status_pkg::ADDR_POWER_MGMT_CONTROL)
       && bus.byteenable[0]
       && pm_code == irq_status_pkg::PM_CLR_ENERGY
       && !rise_ev.energy_wake)
      |=> !status[irq_status_pkg::BIT_ENERGY_WAKE])
      else $error("energy wake bit not cleared");
   // An upper-lane write carries no clear code
   AST_PM_LANE: assert property (
      (wr_take && hit(bus.address, irq_status_pkg::ADDR_POWER_MGMT_CONTROL)
       && !bus.byteenable[0]
       && status[irq_status_pkg::BIT_WAKE_FRAME])
      |=> status[irq_status_pkg::BIT_WAKE_FRAME])
      else $error("wake frame bit cleared without low lane");
   AST_STATUS_READ: assert property (
      (rd_first && hit(bus.address, irq_status_pkg::ADDR_STATUS))
      |=> readdata == {16'h0000, $past(status)})
      else $error("status read data wrong");
   AST_TS_READ: assert property (
      (rd_first && hit(bus.address, irq_status_pkg::ADDR_ENABLE))
      |=> readdata[irq_status_pkg::BIT_TIMESTAMP] == |$past(ptp_ts_enables))
      else $error("timestamp enable read back wrong");
   // Sticky: with no event and no write the word stands
   AST_STICKY: assert property (
      (set_vec == 16'h0000 && !wr_take)
      |=> status == $past(status))
      else $error("status changed with no event or write");
   AST_ENABLE_STORE: assert property (
      (wr_take && hit(bus.address, irq_status_pkg::ADDR_ENABLE) && &lane_mask)
      |=> enable_rw == ($past(wdata) & irq_status_pkg::ENABLE_RW_MASK))
      else $error("enable write not stored through mask");
   AST_PM_STORE: assert property (
      (wr_take && hit(bus.address, irq_status_pkg::ADDR_POWER_MGMT_CONTROL) && &lane_mask)
      |=> pm_ctrl == $past(wdata))
      else $error("power control write not stored");
   // The answer never stretches past one cycle
   AST_ONE_ACK: assert property (ack |=> !ack)
      else $error("answer held too long");

endmodule // host_interrupt_status_logic

// *** logic/irq_status_pkg.sv ***
package irq_status_pkg;

   // ==========================================================
   // Bus geometry
   localparam int unsigned ADDR_W = 12;
   localparam int unsigned DATA_W = 32;
   localparam int unsigned REG_W = 16;

   // ==========================================================
   // Register indices; byte address is four times the index
   localparam int unsigned IDX_ENABLE = 'h190;
   localparam int unsigned IDX_STATUS = 'h192;
   localparam int unsigned IDX_POWER_MGMT_CONTROL = 'h1c0;
   localparam logic [ADDR_W-1:0] ADDR_ENABLE = ADDR_W'(IDX_ENABLE * 4);
   localparam logic [ADDR_W-1:0] ADDR_STATUS = ADDR_W'(IDX_STATUS * 4);
   localparam logic [ADDR_W-1:0] ADDR_POWER_MGMT_CONTROL = ADDR_W'(IDX_POWER_MGMT_CONTROL * 4);

   // ==========================================================
   // Status and enable bit positions
   localparam int unsigned BIT_LINK = 15;
   localparam int unsigned BIT_TX_DONE = 14;
   localparam int unsigned BIT_RX_READY = 13;
   localparam int unsigned BIT_TIMESTAMP = 12;
   localparam int unsigned BIT_RX_OVERRUN = 11;
   localparam int unsigned BIT_TRIGGER = 10;
   localparam int unsigned BIT_TX_STOP = 9;
   localparam int unsigned BIT_RX_STOP = 8;
   localparam int unsigned BIT_TX_SPACE = 6;
   localparam int unsigned BIT_WAKE_FRAME = 5;
   localparam int unsigned BIT_WAKE_PACKET = 4;
   localparam int unsigned BIT_LINKUP_WAKE = 3;
   localparam int unsigned BIT_ENERGY_WAKE = 2;

   // ==========================================================
   // Masks and reset values
   localparam logic [REG_W-1:0] STATUS_W1C_MASK = 16'hff40;
   localparam logic [REG_W-1:0] STATUS_WAKE_MASK = 16'h003c;
   localparam logic [REG_W-1:0] STATUS_IMPL_MASK = 16'hff7c;
   localparam logic [REG_W-1:0] ENABLE_RW_MASK = 16'hebfc;
   localparam logic [REG_W-1:0] REG_RESET = 16'h0000;

   // ==========================================================
   // Power-management clear field
   localparam int unsigned PM_FIELD_LO = 2;
   localparam int unsigned PM_FIELD_HI = 5;
   localparam logic [3:0] PM_CLR_FRAME = 4'h8;
   localparam logic [3:0] PM_CLR_PACKET = 4'h4;
   localparam logic [3:0] PM_CLR_LINKUP = 4'h2;
   localparam logic [3:0] PM_CLR_ENERGY = 4'h1;

   localparam int unsigned PTP_UNITS = 12;

   // ==========================================================
   // Carriers
   typedef struct packed {
      logic [ADDR_W-1:0] address;
      logic read;
      logic write;
      logic [3:0] byteenable;
      logic [DATA_W-1:0] writedata;
   } avalon_req_t;

   typedef struct packed {
      logic link_state;
      logic tx_done;
      logic rx_ready;
      logic [PTP_UNITS-1:0] capture_unit_ready;
      logic egress_ts_ready;
      logic rx_overrun;
      logic [PTP_UNITS-1:0] trig_done;
      logic [PTP_UNITS-1:0] trig_error;
      logic tx_stopped;
      logic rx_stopped;
      logic tx_space;
      logic wake_frame;
      logic wake_packet;
      logic linkup_wake;
      logic energy_wake;
   } event_src_t;

endpackage

// *** tb/host_bus_model.sv ***
`timescale 1ns/1ps
// ==========================================================
// Host processor seen from the register bus
module host_bus_model (
   // Clock
   input wire logic mclk,
   // Avalon-MM master side
   output irq_status_pkg::avalon_req_t bus,
   input wire logic waitrequest,
   input wire logic [irq_status_pkg::DATA_W-1:0] readdata
);
   initial begin
      bus = '0;
   end

   // One transfer; the request is held until waitrequest is seen low at an edge
   task automatic access(input logic rd, input logic [irq_status_pkg::ADDR_W-1:0] addr,
                         input logic [15:0] data, input logic [3:0] be, output logic [15:0] got);
      if (addr == irq_status_pkg::ADDR_ENABLE) begin
         data = data & ~16'h1400;
      end
      @(posedge mclk);
      // Clears go out only as written ones or power-management codes
      bus <= '{address: addr, read: rd, write: ~rd, byteenable: be,
               writedata: {16'h0000, data}};
      @(posedge mclk);
      while (waitrequest !== 1'b0) begin
         @(posedge mclk);
      end
      got = readdata[15:0];
      bus <= '0;
   endtask
endmodule // host_bus_model

// *** tb/host_interrupt_status_logic_tb_top.sv ***
`timescale 1ns/1ps
module host_interrupt_status_logic_tb_top;
   // ==========================================================
   // Stimulus and observation
   logic mclk = 1'b0;
   logic srst = 1'b1;
   logic link = 1'b0;
   logic [46:0] ev_p = '0;
   logic [11:0] ts_en = '0;
   logic [11:0] trig_en = '0;
   irq_status_pkg::avalon_req_t bus;
   irq_status_pkg::event_src_t events;
   logic waitrequest;
   logic [irq_status_pkg::DATA_W-1:0] readdata;
   logic irq;
   int err_count = 0;
   int samples_checked = 0;
   // Flat struct positions of one-shot sources; 47 toggles the link level
   int unsigned w_pos [15] = '{47, 47, 46, 45, 44, 33, 32, 31, 30, 19, 7, 18, 6, 5, 4};
   int unsigned w_bit [15] = '{15, 15, 14, 13, 12, 12, 12, 11, 10, 10, 10, 10, 9, 8, 6};
   logic [3:0] pm_code [4] = '{4'h8, 4'h4, 4'h2, 4'h1};
   logic [15:0] wake_left [4] = '{16'h001c, 16'h000c, 16'h0004, 16'h0000};

   assign events = {link, ev_p};

   host_interrupt_status_logic u_host_interrupt_status_logic (
      .mclk(mclk),
      .srst(srst),
      .bus(bus),
      .waitrequest(waitrequest),
      .readdata(readdata),
      .events(events),
      .ptp_ts_enables(ts_en),
      .ptp_trig_enables(trig_en),
      .irq(irq)
   );

   host_bus_model u_host_bus_model (
      .mclk(mclk),
      .bus(bus),
      .waitrequest(waitrequest),
      .readdata(readdata)
   );

   initial begin
      forever #2.5 mclk = ~mclk;
   end

   // ==========================================================
   // Shared tasks
   task automatic check(input logic [15:0] got, input logic [15:0] exp, input string what);
      samples_checked++;
      if (got !== exp) begin
         err_count++;
         $display("wrong value at %0t: %s got %h expected %h", $time, what, got, exp);
      end
   endtask

   task automatic wr(input logic [11:0] a, input logic [15:0] d, input logic [3:0] be = 4'hf);
      logic [15:0] unused;
      u_host_bus_model.access(1'b0, a, d, be, unused);
   endtask

   task automatic rd_chk(input logic [11:0] a, input logic [15:0] exp, input string what);
      logic [15:0] got;
      u_host_bus_model.access(1'b1, a, 16'h0000, 4'hf, got);
      check(got, exp, what);
   endtask

   // Sources high for one cycle; link is a level, so it only flips
   task automatic fire(input logic [47:0] m);
      @(posedge mclk);
      {link, ev_p} <= {link ^ m[47], m[46:0]};
      @(posedge mclk);
      ev_p <= '0;
      @(negedge mclk);
   endtask

   task automatic end_sim();
      $display("comparisons %0d mismatches %0d", samples_checked, err_count);
      if (err_count == 0 && samples_checked > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask

   // ==========================================================
   // Tests
   initial begin
      repeat (6) @(posedge mclk);
      srst <= 1'b0;
      rd_chk(irq_status_pkg::ADDR_STATUS, 16'h0000, "status at reset");
      rd_chk(irq_status_pkg::ADDR_ENABLE, 16'h0000, "enable at reset");
      wr(12'h004, 16'hffff);
      rd_chk(12'h004, 16'h0000, "unmapped read");
      fire(48'h1 << 46);
      check({15'h0000, irq}, 16'h0000, "irq while disabled");
      rd_chk(irq_status_pkg::ADDR_STATUS, 16'h4000, "latched while disabled");
      wr(irq_status_pkg::ADDR_STATUS, 16'hffff);
      rd_chk(irq_status_pkg::ADDR_STATUS, 16'h0000, "all ones cleared");
      $display("test reset and bus done");

      wr(irq_status_pkg::ADDR_ENABLE, 16'hffff);
      rd_chk(irq_status_pkg::ADDR_ENABLE, 16'hebfc, "enable writable bits");
      @(posedge mclk);
      ts_en <= 12'h400;
      trig_en <= 12'h002;
      rd_chk(irq_status_pkg::ADDR_ENABLE, 16'hfffc, "enable with unit enables");
      wr(irq_status_pkg::ADDR_ENABLE, 16'hebf8);
      fire(48'h1);
      rd_chk(irq_status_pkg::ADDR_STATUS, 16'h0000, "energy wake gated off");
      wr(irq_status_pkg::ADDR_ENABLE, 16'hebfc);
      $display("test enable done");

      // Irq is sampled mid-cycle so the setting or clearing edge has landed
      foreach (w_pos[i]) begin
         fire(48'h1 << w_pos[i]);
         check({15'h0000, irq}, 16'h0001, "irq on event");
         rd_chk(irq_status_pkg::ADDR_STATUS, 16'h1 << w_bit[i], "event bit");
         wr(irq_status_pkg::ADDR_STATUS, ~(16'h1 << w_bit[i]));
         rd_chk(irq_status_pkg::ADDR_STATUS, 16'h1 << w_bit[i], "bit kept");
         wr(irq_status_pkg::ADDR_STATUS, 16'h1 << w_bit[i]);
         @(negedge mclk);
         check({15'h0000, irq}, 16'h0000, "irq after clear");
         rd_chk(irq_status_pkg::ADDR_STATUS, 16'h0000, "bit cleared");
      end
      $display("test event sources done");

      fire(48'h00000000000f);
      check({15'h0000, irq}, 16'h0001, "irq on wake");
      rd_chk(irq_status_pkg::ADDR_STATUS, 16'h003c, "wake bits");
      wr(irq_status_pkg::ADDR_STATUS, 16'h003c);
      rd_chk(irq_status_pkg::ADDR_STATUS, 16'h003c, "wake bits read only");
      foreach (pm_code[i]) begin
         wr(irq_status_pkg::ADDR_POWER_MGMT_CONTROL, {10'h000, pm_code[i], 2'b00});
         rd_chk(irq_status_pkg::ADDR_STATUS, wake_left[i], "wake clear code");
      end
      @(negedge mclk);
      check({15'h0000, irq}, 16'h0000, "irq after wake clear");
      $display("test wake sources done");

      fire(48'h1 << 46);
      wr(irq_status_pkg::ADDR_STATUS, 16'hffff, 4'h1);
      rd_chk(irq_status_pkg::ADDR_STATUS, 16'h4000, "low lane only");
      wr(irq_status_pkg::ADDR_STATUS, 16'hffff, 4'h2);
      rd_chk(irq_status_pkg::ADDR_STATUS, 16'h0000, "high lane clear");
      fire(48'h1 << 3);
      wr(irq_status_pkg::ADDR_POWER_MGMT_CONTROL, 16'h0020, 4'h2);
      rd_chk(irq_status_pkg::ADDR_STATUS, 16'h0020, "code needs low lane");
      rd_chk(irq_status_pkg::ADDR_POWER_MGMT_CONTROL, 16'h0004, "power control store");
      wr(irq_status_pkg::ADDR_POWER_MGMT_CONTROL, 16'h0020);
      rd_chk(irq_status_pkg::ADDR_STATUS, 16'h0000, "frame code clears");
      $display("test byte lanes done");
      end_sim();
   end

   // Whole run is a few hundred cycles; this is ample headroom
   initial begin
      repeat (20000) @(posedge mclk);
      err_count++;
      $display("wrong value at %0t: watchdog expired", $time);
      end_sim();
   end
endmodule // host_interrupt_status_logic_tb_top
